// ### dv/crc_checker.sv
`timescale 1ns/10ps
module crc_checker (
  input wire clk,
  input wire sys_rst,
  input wire host_bus_style_select,
  input wire [4:0] addr,
  input wire wr_stb,
  input wire [7:0] wr_data,
  input wire [7:0] record_event_mask,
  input wire op_step_done,
  input wire decoder_code_error,
  input wire interrupt_request_n,
  input wire [15:0] command_word,
  input wire [7:0] record_event_status_high,
  input wire [2:0] mode,
  input wire busy,
  input wire paused,
  input wire paused_irq,
  input wire port_bus_oe,
  input wire [1:0] pad_expect,
  input wire [1:0] pad_insert,
  input wire history_clear,
  input wire sw_reset_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire hi_wr = wr_stb && !sw_reset_active && addr == (host_bus_style_select ? 5'h10 : 5'h11);
  wire st_wr = wr_stb && addr == (host_bus_style_select ? 5'h0E : 5'h0F);
  property p_irq;
    interrupt_request_n == !(|(record_event_status_high & ~record_event_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");
  property p_start;
    hi_wr && !busy && wr_data == 8'h58 && command_word[7:4] == 4'h0 |=> mode == 3'd2 && busy
      && record_event_status_high == 8'h00 && {pad_expect, pad_insert} == $past(command_word[3:0]);
  endproperty
  a_start: assert property (p_start) else $error("compression start wrong");
  property p_swrst;
    hi_wr && wr_data == 8'hA0 && command_word[7:0] == 8'h00 |=> command_word == 16'hA000
      && record_event_status_high == 8'h00 && mode == 3'd0 && !busy && history_clear;
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset wrong");
  property p_refuse;
    wr_stb && sw_reset_active |=> $stable(command_word);
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken during reset");
  property p_hist;
    hi_wr && wr_data == 8'hA4 && command_word[7:0] == 8'h00 |=> history_clear && mode == $past(mode)
      ##1 !history_clear;
  endproperty
  a_hist: assert property (p_hist) else $error("history clear wrong");
  property p_pause;
    busy && !paused && command_word == 16'h4200 && op_step_done && !wr_stb
      |=> paused && paused_irq && !port_bus_oe;
  endproperty
  a_pause: assert property (p_pause) else $error("pause not completed");
  property p_resume;
    paused && hi_wr && wr_data == 8'h44 && command_word[7:4] == 4'h0 |=> !paused && !paused_irq
      && busy && {pad_expect, pad_insert} == $past(command_word[3:0]);
  endproperty
  a_resume: assert property (p_resume) else $error("resume wrong");
  property p_stat_wr;
    st_wr && mode == 3'd0 |=> record_event_status_high ==
      ($past(record_event_status_high) & $past(wr_data) & 8'hF3);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write wrong");
  property p_dec;
    mode != 3'd0 && !paused && !wr_stb && decoder_code_error |=> record_event_status_high[7];
  endproperty
  a_dec: assert property (p_dec) else $error("decoder end flag missing");
endmodule // crc_checker
bind crc_command_irq crc_checker chk_i (.clk(clk), .sys_rst(sys_rst),
  .host_bus_style_select(host_bus_style_select), .addr(addr), .wr_stb(wr_stb),
  .wr_data(wr_data), .record_event_mask(record_event_mask), .op_step_done(op_step_done),
  .decoder_code_error(decoder_code_error), .interrupt_request_n(interrupt_request_n),
  .command_word(command_word), .record_event_status_high(record_event_status_high),
  .mode(mode), .busy(busy), .paused(paused), .paused_irq(paused_irq),
  .port_bus_oe(port_bus_oe), .pad_expect(pad_expect), .pad_insert(pad_insert),
  .history_clear(history_clear), .sw_reset_active(sw_reset_active));

// ### dv/crc_command_irq_tb_top.sv
`timescale 1ns/10ps
module crc_command_irq_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic host_bus_style_select = 1'b0;
  logic porta_byte_in = 1'b0;
  logic op_step_done = 1'b0;
  logic [7:0] record_event_mask = 8'h00;
  logic [31:0] record_length_load = 32'h0;
  logic [9:0] ev = 10'h000;
  wire [4:0] addr;
  wire wr_stb, rd_stb, interrupt_request_n, busy, paused, paused_irq, port_bus_oe;
  wire bank_a_sel, bank_b_sel, history_clear, sw_reset_active;
  wire [7:0] wr_data, rd_data, record_event_status_high;
  wire [31:0] record_length_counter;
  wire [15:0] command_word;
  wire [2:0] mode;
  wire [1:0] pad_expect, pad_insert;
  wire decoder_eor_code, decoder_code_error, portb_count_ge_compare, portb_last_byte;
  wire portb_one_byte, portb_last_transfer, porta_last_transfer, porta_one_byte;
  wire porta_last_byte_out, transfer_final_word;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  assign {decoder_eor_code, decoder_code_error, portb_count_ge_compare, portb_last_byte,
    portb_one_byte, portb_last_transfer, porta_last_transfer, porta_one_byte,
    porta_last_byte_out, transfer_final_word} = ev;
  // Command, mode, pad expect, pad insert, bank selects
  logic [24:0] rows [0:6] = '{{16'h5009, 3'd1, 2'd2, 2'd1, 2'd0},
    {16'h5806, 3'd2, 2'd1, 2'd2, 2'd0}, {16'h6003, 3'd3, 2'd0, 2'd3, 2'd0},
    {16'h680C, 3'd4, 2'd3, 2'd0, 2'd0}, {16'h6C05, 3'd5, 2'd1, 2'd1, 2'd0},
    {16'hC100, 3'd0, 2'd0, 2'd0, 2'd2}, {16'hC200, 3'd0, 2'd0, 2'd0, 2'd1}};
  crc_command_irq uut (.clk(clk), .sys_rst(sys_rst),
    .host_bus_style_select(host_bus_style_select), .addr(addr), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data), .porta_byte_in(porta_byte_in),
    .porta_last_byte_out(porta_last_byte_out), .porta_one_byte(porta_one_byte),
    .porta_last_transfer(porta_last_transfer), .portb_last_byte(portb_last_byte),
    .portb_one_byte(portb_one_byte), .portb_last_transfer(portb_last_transfer),
    .portb_count_ge_compare(portb_count_ge_compare), .decoder_eor_code(decoder_eor_code),
    .decoder_code_error(decoder_code_error), .transfer_final_word(transfer_final_word),
    .record_event_mask(record_event_mask), .op_step_done(op_step_done),
    .interrupt_request_n(interrupt_request_n), .record_length_counter(record_length_counter),
    .record_length_load(record_length_load), .command_word(command_word),
    .record_event_status_high(record_event_status_high), .mode(mode), .busy(busy),
    .paused(paused), .paused_irq(paused_irq), .port_bus_oe(port_bus_oe),
    .bank_a_sel(bank_a_sel), .bank_b_sel(bank_b_sel), .pad_expect(pad_expect),
    .pad_insert(pad_insert), .history_clear(history_clear),
    .sw_reset_active(sw_reset_active));
  crc_host_model host (.clk(clk), .host_bus_style_select(host_bus_style_select),
    .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data));
  always #5 clk = ~clk;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    begin
      total_checks++;
      if (s !== e) begin
        errors++;
        $display("FAIL %s exp %h got %h", n, e, s);
      end
    end
  endtask
  task ep(input [9:0] v);
    begin
      @(negedge clk);
      ev = v;
      @(negedge clk);
      ev = 10'h000;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    logic [24:0] r;
    logic [7:0] d;
    repeat (6) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk("cmd", command_word, 16'h0000);
    chk("irq", interrupt_request_n, 1'b1);
    host.rd(5'h0F, d);
    chk("status", d, 8'h00);
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      host.cmd(r[24:9]);
      chk("cmd", command_word, r[24:9]);
      chk("mode", mode, r[8:6]);
      chk("pads", {pad_expect, pad_insert}, r[5:2]);
      chk("bank", {bank_a_sel, bank_b_sel}, r[1:0]);
      host.cmd(16'hA000);
    end
    record_length_load = 32'h2;
    host.cmd(16'h5800);
    repeat (2) begin
      @(negedge clk);
      porta_byte_in = 1'b1;
      @(negedge clk);
      porta_byte_in = 1'b0;
    end
    chk("rlc", record_length_counter, 32'h0);
    chk("status", record_event_status_high, 8'h01);
    ep(10'h060);
    chk("status", record_event_status_high, 8'h31);
    ep(10'h00C);
    chk("status", record_event_status_high, 8'h33);
    ep(10'h181);
    chk("status", record_event_status_high, 8'hF3);
    chk("irq", interrupt_request_n, 1'b0);
    record_event_mask = 8'hF3;
    #1;
    chk("irq", interrupt_request_n, 1'b1);
    host.clr(8'h7F);
    chk("status", record_event_status_high, 8'h73);
    ep(10'h200);
    chk("status", record_event_status_high, 8'hF3);
    host.cmd(16'h5800);
    chk("status", record_event_status_high, 8'h00);
    host.cmd(16'h4200);
    @(negedge clk);
    op_step_done = 1'b1;
    @(negedge clk);
    op_step_done = 1'b0;
    chk("pause", {paused, paused_irq, port_bus_oe}, 3'b110);
    host.cmd(16'h4406);
    chk("resume", {paused, paused_irq, busy, pad_expect, pad_insert}, 7'b0010110);
    host.cmd(16'h0000);
    chk("nop", {mode, busy}, 4'b0101);
    ep(10'h100);
    host.wr(5'h10, 8'h00);
    host.wr(5'h11, 8'hA0);
    host.wr(5'h11, 8'h58);
    chk("cmd", command_word, 16'hA000);
    chk("swrst active", sw_reset_active, 1'b1);
    repeat (13) @(negedge clk);
    chk("swrst", {record_event_status_high, mode, busy}, 12'h000);
    chk("swrst active", sw_reset_active, 1'b0);
    host.cmd(16'hA400);
    chk("hist", {history_clear, mode}, 4'h8);
    host_bus_style_select = 1'b1;
    host.cmd(16'h6C0A);
    chk("mode", mode, 3'd5);
    host.rd(5'h10, d);
    chk("cmd hi", d, 8'h6C);
    // Decompression bypass with all four port masks set, then cleared
    host.cmd(16'h6000);
    chk("mode", mode, 3'd3);
    ep(10'h052);
    chk("status", record_event_status_high, 8'h00);
    ep(10'h053);
    chk("status", record_event_status_high, 8'h11);
    record_event_mask = 8'h00;
    ep(10'h076);
    chk("status", record_event_status_high, 8'h33);
    chk("irq", interrupt_request_n, 1'b0);
    // Hardware reset in mid-run
    sys_rst = 1'b1;
    @(negedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk("cmd", command_word, 16'h0000);
    chk("status", {record_event_status_high, mode}, 11'h000);
    ep(10'h180);
    chk("status", record_event_status_high, 8'hC0);
    host.clr(8'h7F);
    chk("status", record_event_status_high, 8'h40);
    finish_test();
  end
endmodule // crc_command_irq_tb_top

// ### dv/crc_host_model.sv
`timescale 1ns/10ps
`include "crc_consts.vh"
module crc_host_model (
  input wire clk,
  input wire host_bus_style_select,
  output reg [4:0] addr,
  output reg wr_stb,
  output reg rd_stb,
  output reg [7:0] wr_data,
  input wire [7:0] rd_data
);
  initial begin
    addr = 5'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_data = 8'h00;
  end
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wr_data = d;
      wr_stb = 1'b1;
      @(negedge clk);
      wr_stb = 1'b0;
      wr_data = ~d;
    end
  endtask
  // Sends any command word, low byte first
  task cmd(input [15:0] c);
    begin
      wr({4'h8, host_bus_style_select}, c[7:0]);
      wr({4'h8, !host_bus_style_select}, c[15:8]);
      if (c == `CRC_OP_SWRST) repeat (13) @(negedge clk);
    end
  endtask
  // Zero bits clear, one bits keep
  task clr(input [7:0] keep);
    wr({4'h7, !host_bus_style_select}, keep);
  endtask
  task rd(input [4:0] a, output [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      rd_stb = 1'b1;
      @(negedge clk);
      rd_stb = 1'b0;
      @(negedge clk);
      d = rd_data;
    end
  endtask
endmodule // crc_host_model

// ### logic/crc_cmd_decode.v
`timescale 1ns/10ps
`include "crc_consts.vh"
// Classifies a command word into one-hot opcode strobes
module crc_cmd_decode (
  input wire [15:0] cmd,
  output wire is_sel_a,
  output wire is_sel_b,
  output wire is_cbyp,
  output wire is_comp,
  output wire is_dbyp,
  output wire is_dcmp,
  output wire is_ddis,
  output wire is_pause,
  output wire is_resume,
  output wire is_swrst,
  output wire is_hist
);
  assign is_sel_a = (cmd == `CRC_OP_SEL_A);
  assign is_sel_b = (cmd == `CRC_OP_SEL_B);
  assign is_cbyp = (cmd[15:4] == `CRC_OPH_CBYP);
  assign is_comp = (cmd[15:4] == `CRC_OPH_COMP);
  assign is_dbyp = (cmd[15:4] == `CRC_OPH_DBYP);
  assign is_dcmp = (cmd[15:4] == `CRC_OPH_DCMP);
  assign is_ddis = (cmd[15:4] == `CRC_OPH_DDIS);
  assign is_pause = (cmd == `CRC_OP_PAUSE);
  assign is_resume = (cmd[15:4] == `CRC_OPH_RESUME);
  assign is_swrst = (cmd == `CRC_OP_SWRST);
  assign is_hist = (cmd == `CRC_OP_HIST);
endmodule // crc_cmd_decode

// ### logic/crc_command_irq.v
`timescale 1ns/10ps
`include "crc_consts.vh"
// Command word and record event status byte, byte-wide host register port
module crc_command_irq (
  input wire clk,
  input wire sys_rst,
  input wire host_bus_style_select,
  input wire [4:0] addr,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  input wire porta_byte_in,
  input wire porta_last_byte_out,
  input wire porta_one_byte,
  input wire porta_last_transfer,
  input wire portb_last_byte,
  input wire portb_one_byte,
  input wire portb_last_transfer,
  input wire portb_count_ge_compare,
  input wire decoder_eor_code,
  input wire decoder_code_error,
  input wire transfer_final_word,
  input wire [7:0] record_event_mask,
  input wire op_step_done,
  output wire interrupt_request_n,
  output reg [31:0] record_length_counter,
  input wire [31:0] record_length_load,
  output reg [15:0] command_word,
  output reg [7:0] record_event_status_high,
  output reg [2:0] mode,
  output reg busy,
  output reg paused,
  output reg paused_irq,
  output reg port_bus_oe,
  output reg bank_a_sel,
  output reg bank_b_sel,
  output reg [1:0] pad_expect,
  output reg [1:0] pad_insert,
  output reg history_clear,
  output reg sw_reset_active
);
  localparam M_IDLE = 3'd0;
  localparam M_CBYP = 3'd1;
  localparam M_COMP = 3'd2;
  localparam M_DBYP = 3'd3;
  localparam M_DCMP = 3'd4;
  localparam M_DDIS = 3'd5;
  localparam S_RUN = 3'b001;
  localparam S_PEND = 3'b010;
  localparam S_HOLD = 3'b100;

  reg [2:0] pstate;
  reg [3:0] rst_cnt;
  reg [7:0] next_status;
  reg [7:0] ev;
  reg [7:0] clr_mask;
  reg [15:0] next_cmd;
  wire is_sel_a, is_sel_b, is_cbyp, is_comp, is_dbyp, is_dcmp, is_ddis;
  wire is_pause, is_resume, is_swrst, is_hist;
  wire status_hit;
  wire cmd_lo_hit;
  wire cmd_hi_hit;
  wire comp_mode;
  wire decomp_mode;
  wire all_port_masks;
  wire cmd_write;
  wire new_comp;

  // HOST_BUS_STYLE_SELECT=1 swaps the byte lanes of each register pair
  function [4:0] swap_addr;
    input [4:0] a;
    input sel;
    begin
      swap_addr = sel ? {a[4:1], ~a[0]} : a;
    end
  endfunction

  // Pad field as unsigned count 0..3
  function [1:0] pad_field;
    input [1:0] f;
    begin
      pad_field = f;
    end
  endfunction

  wire [4:0] eff_addr = swap_addr(addr, host_bus_style_select);
  assign status_hit = (eff_addr == `CRC_ADDR_STATUS_M0);
  assign cmd_lo_hit = (eff_addr == `CRC_ADDR_CMD_LO_M0);
  assign cmd_hi_hit = (eff_addr == `CRC_ADDR_CMD_HI_M0);

  always @* begin
    next_cmd = command_word;
    if (cmd_lo_hit) begin
      next_cmd[7:0] = wr_data;
    end
    if (cmd_hi_hit) begin
      next_cmd[15:8] = wr_data;
    end
  end

  // Command executes when the high byte lands
  assign cmd_write = wr_stb && cmd_hi_hit && !sw_reset_active;

  crc_cmd_decode u_dec (
    .cmd(next_cmd),
    .is_sel_a(is_sel_a),
    .is_sel_b(is_sel_b),
    .is_cbyp(is_cbyp),
    .is_comp(is_comp),
    .is_dbyp(is_dbyp),
    .is_dcmp(is_dcmp),
    .is_ddis(is_ddis),
    .is_pause(is_pause),
    .is_resume(is_resume),
    .is_swrst(is_swrst),
    .is_hist(is_hist)
  );

  assign new_comp = cmd_write && (is_cbyp || is_comp);
  assign comp_mode = (mode == M_CBYP) || (mode == M_COMP);
  assign decomp_mode = (mode == M_DBYP) || (mode == M_DCMP) || (mode == M_DDIS);
  assign all_port_masks = record_event_mask[`CRC_BIT_BPB] && record_event_mask[`CRC_BIT_PORTB_RECORD_END_FLAG]
    && record_event_mask[`CRC_BIT_BPA] && record_event_mask[`CRC_BIT_PORTA_RECORD_END_FLAG];

  // Raw hardware events for this cycle
  always @* begin
    ev = 8'h00;
    ev[`CRC_BIT_DECODER_RECORD_END_FLAG] = decoder_eor_code || decoder_code_error;
    ev[`CRC_BIT_PORTB_COMPARE_FLAG] = portb_count_ge_compare;
    if (comp_mode) begin
      ev[`CRC_BIT_PORTB_RECORD_END_FLAG] = portb_last_byte;
      ev[`CRC_BIT_BPB] = portb_last_byte && portb_one_byte;
      ev[`CRC_BIT_PORTA_RECORD_END_FLAG] = porta_byte_in && (record_length_counter == 32'h00000001);
      ev[`CRC_BIT_BPA] = porta_last_transfer && porta_one_byte;
    end else if (decomp_mode) begin
      ev[`CRC_BIT_PORTA_RECORD_END_FLAG] = porta_last_byte_out;
      ev[`CRC_BIT_BPA] = porta_last_byte_out && porta_one_byte;
      if (mode == M_DBYP) begin
        ev[`CRC_BIT_PORTB_RECORD_END_FLAG] = portb_last_byte;
        ev[`CRC_BIT_BPB] = portb_last_transfer && portb_one_byte;
      end
    end
    if (all_port_masks && !transfer_final_word) begin
      ev[`CRC_BIT_BPB] = 1'b0;
      ev[`CRC_BIT_PORTB_RECORD_END_FLAG] = 1'b0;
      ev[`CRC_BIT_BPA] = 1'b0;
      ev[`CRC_BIT_PORTA_RECORD_END_FLAG] = 1'b0;
    end
    if (paused || mode == M_IDLE) begin
      ev[`CRC_BIT_BPB] = 1'b0;
      ev[`CRC_BIT_PORTB_RECORD_END_FLAG] = 1'b0;
      ev[`CRC_BIT_BPA] = 1'b0;
      ev[`CRC_BIT_PORTA_RECORD_END_FLAG] = 1'b0;
    end
  end

  // Zero bits clear, one bits keep; a same-cycle event wins
  always @* begin
    clr_mask = 8'hFF;
    if (wr_stb && status_hit) begin
      clr_mask = wr_data | 8'h0C;
    end
    next_status = (record_event_status_high & clr_mask) | (ev & 8'hF3);
    if (new_comp) begin
      next_status = `CRC_STATUS_RESET;
    end
  end

  assign interrupt_request_n = ~|(record_event_status_high & ~record_event_mask & 8'hF3);

  always @(posedge clk) begin
    if (sys_rst) begin
      command_word <= `CRC_CMD_HW_RESET;
      record_event_status_high <= `CRC_STATUS_RESET;
      mode <= M_IDLE;
      busy <= 1'b0;
      paused <= 1'b0;
      paused_irq <= 1'b0;
      pstate <= S_RUN;
      port_bus_oe <= 1'b0;
      bank_a_sel <= 1'b0;
      bank_b_sel <= 1'b0;
      pad_expect <= 2'h0;
      pad_insert <= 2'h0;
      history_clear <= 1'b0;
      sw_reset_active <= 1'b0;
      rst_cnt <= 4'h0;
      record_length_counter <= 32'h00000000;
      rd_data <= 8'h00;
    end else begin
      history_clear <= 1'b0;
      record_event_status_high <= next_status;
      if (rd_stb) begin
        if (status_hit) begin
          rd_data <= record_event_status_high;
        end else if (cmd_lo_hit) begin
          rd_data <= command_word[7:0];
        end else if (cmd_hi_hit) begin
          rd_data <= command_word[15:8];
        end else begin
          rd_data <= 8'h00;
        end
      end
      if (comp_mode && busy && !paused && porta_byte_in) begin
        record_length_counter <= record_length_counter - 32'h00000001;
      end
      if (sw_reset_active) begin
        if (rst_cnt == 4'h1) begin
          sw_reset_active <= 1'b0;
        end
        rst_cnt <= rst_cnt - 4'h1;
      end else if (wr_stb && cmd_lo_hit) begin
        command_word <= next_cmd;
      end else if (cmd_write) begin
        command_word <= next_cmd;
        bank_a_sel <= is_sel_a;
        bank_b_sel <= is_sel_b;
        if (is_swrst) begin
          command_word <= `CRC_OP_SWRST;
          record_event_status_high <= `CRC_STATUS_RESET;
          mode <= M_IDLE;
          busy <= 1'b0;
          paused <= 1'b0;
          paused_irq <= 1'b0;
          pstate <= S_RUN;
          port_bus_oe <= 1'b0;
          pad_expect <= 2'h0;
          pad_insert <= 2'h0;
          record_length_counter <= 32'h00000000;
          history_clear <= 1'b1;
          sw_reset_active <= 1'b1;
          rst_cnt <= `CRC_SWRST_CYC;
        end else if (is_hist) begin
          history_clear <= 1'b1;
        end else if (is_cbyp || is_comp || is_dbyp || is_dcmp || is_ddis) begin
          mode <= is_cbyp ? M_CBYP : is_comp ? M_COMP : is_dbyp ? M_DBYP :
            is_dcmp ? M_DCMP : M_DDIS;
          pad_expect <= pad_field(next_cmd[3:2]);
          pad_insert <= pad_field(next_cmd[1:0]);
          busy <= 1'b1;
          paused <= 1'b0;
          pstate <= S_RUN;
          port_bus_oe <= 1'b1;
          if (is_cbyp || is_comp) begin
            paused_irq <= 1'b0;
            record_length_counter <= record_length_load;
          end
        end else if (is_pause && busy && pstate == S_RUN) begin
          pstate <= S_PEND;
        end else if (is_resume && pstate == S_HOLD) begin
          pstate <= S_RUN;
          paused <= 1'b0;
          paused_irq <= 1'b0;
          busy <= 1'b1;
          port_bus_oe <= 1'b1;
          pad_expect <= pad_field(next_cmd[3:2]);
          pad_insert <= pad_field(next_cmd[1:0]);
        end
        // Opcode 0x0000 and unknown values fall through; only the word is stored and both bank selects clear
      end
      if (!sw_reset_active && !cmd_write) begin
        case (pstate)
          S_RUN: begin
            pstate <= S_RUN;
          end
          S_PEND: begin
            if (op_step_done) begin
              port_bus_oe <= 1'b0;
              paused <= 1'b1;
              paused_irq <= 1'b1;
              busy <= 1'b0;
              pstate <= S_HOLD;
            end
          end
          S_HOLD: begin
            pstate <= S_HOLD;
          end
          default: begin
            pstate <= S_RUN;
          end
        endcase
      end
    end
  end
endmodule // crc_command_irq

// ### logic/crc_consts.vh
// Behaviour
// - With all four port masks set, port flags rise only after final transfer word.
// - Decoder end flag bit 15 sets on end-of-record code or invalid code error.
// - Port B compare flag bit 14 sets while transfer count >= compare count.
// - Compression modes: port B single-byte flag sets with port B end when one byte.
// - Decompression bypass: port B single-byte flag sets on final one-byte record transfer.
// - Port B end flag bit 12 on last record byte out or in.
// - Port A single-byte flag bit 9 on one-byte final transfer or end.
// - Port A end flag bit 8 when record length hits zero or last byte out.
// - Status byte clears on reset, interrupt-reset write, and new compression transfer.
// - Status byte reads 0x00 after hardware and software reset.
// - Command word is 0x0000 on hardware reset, 0xA000 after software reset.
// - 0xC100 selects port A config bank, 0xC200 selects port B config bank.
// - 0x500x bypass, 0x580x compression; bits 3:2 port A pads, 1:0 port B pads.
// - 0x600x, 0x680x, 0x6C0x decompression kinds; bits 3:2 port B, 1:0 port A pads.
// - Pause 0x4200 finishes steps, floats port buses, sets paused interrupt and status.
// - Resume 0x440x continues, clears paused bits, sets busy, loads pad counts.
// - Software reset 0xA000 resets all but config, polarity, ID; clears history.
// - 0xA400 clears history buffer and both bank selects; host uses it between compressions.
// - Opcode 0x0000 changes no state except storing the word and clearing both bank selects.
// - Writing zero to a status bit clears it; writing one leaves it.
// - A mask bit of one blocks its status bit from the interrupt request.
// - Record length counter decrements per byte into port A in compression modes.
`ifndef CRC_CONSTS_VH
`define CRC_CONSTS_VH
`define CRC_ADDR_STATUS_M0 5'h0F
`define CRC_ADDR_STATUS_M1 5'h0E
`define CRC_ADDR_CMD_LO_M0 5'h10
`define CRC_ADDR_CMD_HI_M0 5'h11
`define CRC_STATUS_RESET 8'h00
`define CRC_CMD_HW_RESET 16'h0000
`define CRC_OP_NOP 16'h0000
`define CRC_OP_SEL_A 16'hC100
`define CRC_OP_SEL_B 16'hC200
`define CRC_OP_PAUSE 16'h4200
`define CRC_OP_SWRST 16'hA000
`define CRC_OP_HIST 16'hA400
`define CRC_OPH_CBYP 12'h500
`define CRC_OPH_COMP 12'h580
`define CRC_OPH_DBYP 12'h600
`define CRC_OPH_DCMP 12'h680
`define CRC_OPH_DDIS 12'h6C0
`define CRC_OPH_RESUME 12'h440
`define CRC_BIT_DECODER_RECORD_END_FLAG 7
`define CRC_BIT_PORTB_COMPARE_FLAG 6
`define CRC_BIT_BPB 5
`define CRC_BIT_PORTB_RECORD_END_FLAG 4
`define CRC_BIT_BPA 1
`define CRC_BIT_PORTA_RECORD_END_FLAG 0
`define CRC_SWRST_CYC 4'hC
`endif
